/* File: rtl/radar_read_regs.vh */
// constants for the radar data read sequencer
`ifndef RADAR_READ_REGS_VH
`define RADAR_READ_REGS_VH
`define CLK_PERIOD_NS        10
`define RATE_INTERVAL_US     80000
`define RATE_INTERVAL_CYC    (`RATE_INTERVAL_US * 1000 / `CLK_PERIOD_NS)
`define RATE_MID_CYC         (`RATE_INTERVAL_CYC / 2)
`define CODE_HOLDOFF_S       50
`define CODE_HOLDOFF_CYC     40'h012a05f200
`define UPDATE_SPACING_S     64
`define UPDATE_SPACING_CYC   40'h017d784000
`define FINE_REPEAT_COUNT    2'h2
`define SIDE_LOBE_LIMIT      16'h0003
`define BORESIGHT_LIMIT      16'h001e
`define RANGE_WORD_W         15
`define RATE_COUNT_W         16
`define RESULT_W             32
`endif

/* File: rtl/interval_timer.v */
// elapsed-interval timer: reports when a holdoff has run out since last restart
module interval_timer #(
  parameter [39:0] LIMIT = 40'h0000000010
) (
  input  wire sys_clk_in,
  input  wire reset_in,
  input  wire restart_in,
  output reg  expired_out
);
  reg [39:0] count;

  // expired from reset so the very first event is never held off
  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      count       <= 40'h0000000000;
      expired_out <= 1'b1;
    end else if (restart_in) begin
      count       <= 40'h0000000000;
      expired_out <= 1'b0;
    end else if (!expired_out) begin
      count <= count + 40'h0000000001;
      if (count >= LIMIT - 40'h0000000002) begin
        expired_out <= 1'b1;
      end
    end
  end
endmodule // interval_timer

/* File: rtl/radar_read_sequencer.v */
// radar data read sequencer: checks discretes, reads, scales, tags, gates updates
// What this block does
// RULE1 - each pass starts by testing tracking permission; no request or routine without it
// RULE2 - velocity-change maneuver clears tracking permission, suppressing data requests
// RULE3 - with permission, verify track-enable issued and auto-mode received before reading
// RULE4 - track-enable absent: abandon read, request attitude and re-designation
// RULE5 - no read while encoders zero; rendezvous calls fine attitude with count 2
// RULE6 - data-good lost during readout lights tracker-fail and re-designates
// RULE7 - encoder failure during readout aborts read and re-designates
// RULE8 - radar asserts low-range-scale below 9.38 times 32767 feet
// RULE9 - range scale sampled before and after; mismatch discards set and re-requests
// RULE10 - range is word times short or long bit weight per scale discrete
// RULE11 - rate is scale times count minus bias frequency times 80 ms interval
// RULE12 - one time tag per set, taken at middle of 80 ms rate interval
// RULE13 - announce data to backup system at most once per 50 seconds
// RULE14 - line of sight versus encoders over 3 degrees: alarm, await operator choice
// RULE15 - antenna beyond 30 degrees of +z axis calls preferred attitude routine
// RULE16 - update suppressed if temporary permission off or permanent inhibit set
// RULE17 - inhibit set by operator, cleared when operator selects vehicle to update
// RULE18 - reading needs only tracking permission, regardless of update flags
// RULE19 - rendezvous program invokes fine attitude routine repeatedly
// RULE20 - rendezvous updates with full set at most once per 64 seconds
// RULE21 - after any pass return to idle with measurement registers invalidated; code keeps set_valid_out until the next trigger
`include "radar_read_regs.vh"
module radar_read_sequencer (
  input  wire                      sys_clk_in,
  input  wire                      reset_in,
  input  wire                      read_trigger_in,
  input  wire                      rendezvous_mode_in,
  input  wire                      maneuver_active_in,
  input  wire                      track_grant_in,
  input  wire                      track_enable_in,
  input  wire                      auto_mode_in,
  input  wire                      encoder_zeroing_in,
  input  wire                      encoder_fail_in,
  input  wire                      data_good_in,
  input  wire                      low_range_scale_in,
  input  wire                      data_ready_in,
  input  wire [`RANGE_WORD_W-1:0]  range_word_in,
  input  wire [`RATE_COUNT_W-1:0]  range_rate_count_in,
  input  wire [15:0]               long_range_bit_weight_in,
  input  wire [15:0]               short_range_bit_weight_in,
  input  wire [15:0]               range_rate_scale_in,
  input  wire [15:0]               rate_bias_product_in,
  input  wire [31:0]               mission_time_in,
  input  wire [15:0]               los_error_deg_in,
  input  wire [15:0]               boresight_angle_deg_in,
  input  wire                      operator_proceed_in,
  input  wire                      operator_redesignate_in,
  input  wire                      update_permit_in,
  input  wire                      inhibit_request_in,
  input  wire                      vehicle_select_in,
  output reg                       data_request_out,
  output reg                       redesignate_out,
  output reg                       fine_attitude_out,
  output reg  [1:0]                fine_repeat_out,
  output reg                       preferred_attitude_out,
  output reg                       tracker_fail_out,
  output reg                       side_lobe_alarm_out,
  output reg                       backup_code_out,
  output reg                       nav_update_out,
  output reg                       set_valid_out,
  output reg  [`RESULT_W-1:0]      range_out,
  output reg  [`RESULT_W-1:0]      range_rate_out,
  output reg  [31:0]               time_tag_out,
  output reg                       update_inhibit_out,
  output reg                       track_permit_out
);
  // ************************************************************
  // states
  // ************************************************************
  localparam [2:0] S_IDLE  = 3'h0;
  localparam [2:0] S_CHECK = 3'h1;
  localparam [2:0] S_READ  = 3'h2;
  localparam [2:0] S_LOBE  = 3'h3;
  localparam [2:0] S_ANGLE = 3'h4;
  localparam [2:0] S_NAV   = 3'h5;

  reg [2:0]  state;
  reg        scale_before;
  reg [31:0] tag_count;
  reg        tag_taken;
  wire       code_ok;
  wire       update_ok;
  wire       rdy_ok;

  // combined discrete test, used only during readout once data is ready
  function link_ok;
    input good;
    input fail;
    begin
      link_ok = good & ~fail;
    end
  endfunction

  assign rdy_ok = link_ok(data_good_in, encoder_fail_in);

  // ************************************************************
  // holdoff timers
  // ************************************************************
  interval_timer #(.LIMIT(`CODE_HOLDOFF_CYC)) code_timer ( // RULE13
    .sys_clk_in  (sys_clk_in),
    .reset_in    (reset_in),
    .restart_in  (backup_code_out),
    .expired_out (code_ok)
  );

  interval_timer #(.LIMIT(`UPDATE_SPACING_CYC)) update_timer ( // RULE20
    .sys_clk_in  (sys_clk_in),
    .reset_in    (reset_in),
    .restart_in  (nav_update_out),
    .expired_out (update_ok)
  );

  // ************************************************************
  // flags
  // ************************************************************
  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      update_inhibit_out <= 1'b0;
      track_permit_out   <= 1'b0;
    end else begin
      track_permit_out <= track_grant_in & ~maneuver_active_in; // RULE2
      if (vehicle_select_in) begin
        update_inhibit_out <= 1'b0; // RULE17
      end else if (inhibit_request_in) begin
        update_inhibit_out <= 1'b1; // RULE17
      end
    end
  end

  // ************************************************************
  // sequencer
  // ************************************************************
  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      state                  <= S_IDLE;
      scale_before           <= 1'b0;
      tag_count              <= 32'h00000000;
      tag_taken              <= 1'b0;
      data_request_out       <= 1'b0;
      redesignate_out        <= 1'b0;
      fine_attitude_out      <= 1'b0;
      fine_repeat_out        <= 2'h0;
      preferred_attitude_out <= 1'b0;
      tracker_fail_out       <= 1'b0;
      side_lobe_alarm_out    <= 1'b0;
      backup_code_out        <= 1'b0;
      nav_update_out         <= 1'b0;
      set_valid_out          <= 1'b0;
      range_out              <= 32'h00000000;
      range_rate_out         <= 32'h00000000;
      time_tag_out           <= 32'h00000000;
    end else begin
      redesignate_out        <= 1'b0;
      fine_attitude_out      <= 1'b0;
      preferred_attitude_out <= 1'b0;
      backup_code_out        <= 1'b0;
      nav_update_out         <= 1'b0;
      case (state)
        S_IDLE: begin
          data_request_out <= 1'b0;
          if (read_trigger_in) begin
            set_valid_out <= 1'b0; // RULE21
            state         <= S_CHECK;
          end
        end
        S_CHECK: begin
          if (!track_permit_out) begin
            state <= S_IDLE; // RULE1
          end else if (!track_enable_in) begin
            preferred_attitude_out <= 1'b1; // RULE4
            redesignate_out        <= 1'b1; // RULE4
            state                  <= S_IDLE;
          end else if (!auto_mode_in) begin
            state <= S_IDLE; // RULE3
          end else if (encoder_zeroing_in) begin
            if (rendezvous_mode_in) begin
              fine_attitude_out <= 1'b1; // RULE5
              fine_repeat_out   <= `FINE_REPEAT_COUNT;
            end
            state <= S_IDLE;
          end else begin
            scale_before     <= low_range_scale_in; // RULE9
            data_request_out <= 1'b1; // RULE3
            tag_count        <= 32'h00000000;
            tag_taken        <= 1'b0;
            state            <= S_READ;
          end
        end
        S_READ: begin
          tag_count <= tag_count + 32'h00000001;
          if (!tag_taken && tag_count == `RATE_MID_CYC) begin
            time_tag_out <= mission_time_in; // RULE12
            tag_taken    <= 1'b1;
          end
          if (!data_good_in) begin
            tracker_fail_out <= 1'b1; // RULE6
            redesignate_out  <= 1'b1; // RULE6
            data_request_out <= 1'b0;
            state            <= S_IDLE;
          end else if (encoder_fail_in) begin
            redesignate_out  <= 1'b1; // RULE7
            data_request_out <= 1'b0;
            state            <= S_IDLE;
          end else if (data_ready_in && rdy_ok) begin
            if (low_range_scale_in != scale_before) begin
              // discard and ask again at once, restarting the tag interval
              scale_before <= low_range_scale_in; // RULE9
              tag_count    <= 32'h00000000;
              tag_taken    <= 1'b0;
            end else begin
              data_request_out <= 1'b0;
              range_out <= low_range_scale_in ? // RULE10
                           range_word_in * short_range_bit_weight_in :
                           range_word_in * long_range_bit_weight_in;
              range_rate_out <= $signed(range_rate_scale_in) * // RULE11
                                ($signed({16'h0000, range_rate_count_in}) -
                                 $signed({16'h0000, rate_bias_product_in}));
              if (code_ok) begin
                backup_code_out <= 1'b1; // RULE13
              end
              state <= S_LOBE;
            end
          end
        end
        S_LOBE: begin
          if (los_error_deg_in <= `SIDE_LOBE_LIMIT || operator_proceed_in) begin
            side_lobe_alarm_out <= 1'b0;
            state               <= S_ANGLE;
          end else if (operator_redesignate_in) begin
            side_lobe_alarm_out <= 1'b0;
            redesignate_out     <= 1'b1;
            state               <= S_IDLE;
          end else begin
            side_lobe_alarm_out <= 1'b1; // RULE14
          end
        end
        S_ANGLE: begin
          // data stays valid even if the update is later refused
          set_valid_out <= 1'b1; // RULE18
          if (track_permit_out && boresight_angle_deg_in > `BORESIGHT_LIMIT) begin
            preferred_attitude_out <= 1'b1; // RULE15
            state                  <= S_IDLE;
          end else begin
            state <= S_NAV;
          end
        end
        S_NAV: begin
          if (update_permit_in && !update_inhibit_out &&
              (update_ok || !rendezvous_mode_in)) begin
            nav_update_out <= 1'b1; // RULE16 RULE20
          end
          if (rendezvous_mode_in && track_permit_out) begin
            fine_attitude_out <= 1'b1; // RULE19
          end
          state <= S_IDLE; // RULE21
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end
endmodule // radar_read_sequencer

/* File: verification/radar_read_props.sv */
// assertion checker for the radar data read sequencer
module radar_read_props (
  input wire       sys_clk_in,
  input wire       reset_in,
  input wire       maneuver_active_in,
  input wire       track_enable_in,
  input wire       auto_mode_in,
  input wire       encoder_zeroing_in,
  input wire       encoder_fail_in,
  input wire       data_good_in,
  input wire       update_permit_in,
  input wire       vehicle_select_in,
  input wire       data_request_out,
  input wire       fine_attitude_out,
  input wire [1:0] fine_repeat_out,
  input wire       tracker_fail_out,
  input wire       side_lobe_alarm_out,
  input wire       nav_update_out,
  input wire       update_inhibit_out,
  input wire       track_permit_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  a_req_needs_permit: assert property ($rose(data_request_out) |-> $past(track_permit_out))
    else $error("request without permission");
  a_maneuver_clears: assert property (maneuver_active_in |=> !track_permit_out)
    else $error("permission kept in maneuver");
  a_req_needs_modes: assert property ($rose(data_request_out) |->
    $past(track_enable_in) && $past(auto_mode_in))
    else $error("request without enable or auto mode");
  a_no_zero_read: assert property ($rose(data_request_out) |-> !$past(encoder_zeroing_in))
    else $error("request while zeroing");
  a_fine_count: assert property (fine_attitude_out && encoder_zeroing_in |=> fine_repeat_out == 2'h2)
    else $error("fine repeat count wrong");
  a_good_loss_fail: assert property (data_request_out && !data_good_in |-> ##[1:3] tracker_fail_out)
    else $error("no tracker fail");
  a_fail_sticky: assert property (tracker_fail_out |=> tracker_fail_out)
    else $error("tracker fail dropped");
  a_enc_abort: assert property (data_request_out && encoder_fail_in |-> ##[1:3] !data_request_out)
    else $error("read not aborted");
  a_update_gated: assert property (nav_update_out |->
    $past(update_permit_in) && !$past(update_inhibit_out))
    else $error("update not gated");
  a_inhibit_clear: assert property (vehicle_select_in |=> !update_inhibit_out)
    else $error("inhibit not cleared");
  a_lobe_holds: assert property (side_lobe_alarm_out |-> !nav_update_out)
    else $error("update during alarm");
  cover property (nav_update_out);
  cover property (fine_attitude_out && encoder_zeroing_in);
  cover property (tracker_fail_out);
  cover property (side_lobe_alarm_out);
endmodule // radar_read_props
bind radar_read_sequencer radar_read_props radar_read_props_i (.sys_clk_in(sys_clk_in),
  .reset_in(reset_in), .maneuver_active_in(maneuver_active_in), .track_enable_in(track_enable_in),
  .auto_mode_in(auto_mode_in), .encoder_zeroing_in(encoder_zeroing_in),
  .encoder_fail_in(encoder_fail_in), .data_good_in(data_good_in),
  .update_permit_in(update_permit_in), .vehicle_select_in(vehicle_select_in),
  .data_request_out(data_request_out), .fine_attitude_out(fine_attitude_out),
  .fine_repeat_out(fine_repeat_out), .tracker_fail_out(tracker_fail_out),
  .side_lobe_alarm_out(side_lobe_alarm_out), .nav_update_out(nav_update_out),
  .update_inhibit_out(update_inhibit_out), .track_permit_out(track_permit_out));

/* File: verification/radar_model.sv */
// behavioural rendezvous radar answering data requests
module radar_model #(
  parameter DELAY   = 6,
  parameter SHORT_W = 10,
  parameter LONG_W  = 100
) (
  input  wire        sys_clk_in,
  input  wire        request_in,
  input  wire        drop_good_in,
  input  wire [31:0] range_ft_in,
  output reg         data_ready_out = 1'b0,
  output wire        data_good_out,
  output wire        low_range_scale_out,
  output reg  [14:0] range_word_out = 15'h0,
  output reg  [15:0] rate_count_out = 16'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  integer wait_cnt = 0;
  assign low_range_scale_out = range_ft_in < 32'd307355;
  assign data_good_out = ~(request_in & drop_good_in);
  always @(posedge sys_clk_in) begin
    wait_cnt <= request_in ? wait_cnt + 1 : 0;
    data_ready_out <= request_in && wait_cnt >= DELAY;
    // words toggle when not released so a stale capture is caught
    if (request_in && wait_cnt >= DELAY) begin
      range_word_out <= 15'(low_range_scale_out ? range_ft_in / SHORT_W : range_ft_in / LONG_W);
      rate_count_out <= 16'h044c;
    end else begin
      range_word_out <= ~range_word_out;
      rate_count_out <= ~rate_count_out;
    end
  end
endmodule // radar_model

/* File: verification/radar_read_sequencer_tb.sv */
// self-checking bench for the radar data read sequencer
module radar_read_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_in, reset_in, trig, rdv, man, grant, en, auto, zero, efail, permit, inh, vsel, drop;
  logic [31:0] ft, rng, rt;
  logic [6:0] seen;
  logic [15:0] line_of_sight, bore;
  logic proceed, redes_op;
  wire ready, good, low, req, redes, fine, pref, tfail, lobe, bk, nav, vld, inhib, tperm;
  wire [14:0] word;
  wire [15:0] cnt;
  wire [1:0] frep;
  wire [31:0] range_out, range_rate_out;
  int err_total = 0;
  int checks_done = 0;
  radar_read_sequencer radar_read_sequencer_i (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
    .read_trigger_in(trig), .rendezvous_mode_in(rdv), .maneuver_active_in(man),
    .track_grant_in(grant), .track_enable_in(en), .auto_mode_in(auto),
    .encoder_zeroing_in(zero), .encoder_fail_in(efail), .data_good_in(good),
    .low_range_scale_in(low), .data_ready_in(ready), .range_word_in(word),
    .range_rate_count_in(cnt), .long_range_bit_weight_in(16'h0064),
    .short_range_bit_weight_in(16'h000a), .range_rate_scale_in(16'h0003),
    .rate_bias_product_in(16'h03e8), .mission_time_in(32'h0), .los_error_deg_in(line_of_sight),
    .boresight_angle_deg_in(bore), .operator_proceed_in(proceed),
    .operator_redesignate_in(redes_op),
    .update_permit_in(permit), .inhibit_request_in(inh), .vehicle_select_in(vsel),
    .data_request_out(req), .redesignate_out(redes), .fine_attitude_out(fine),
    .fine_repeat_out(frep), .preferred_attitude_out(pref), .tracker_fail_out(tfail),
    .side_lobe_alarm_out(lobe), .backup_code_out(bk), .nav_update_out(nav),
    .set_valid_out(vld), .range_out(range_out), .range_rate_out(range_rate_out),
    .time_tag_out(), .update_inhibit_out(inhib), .track_permit_out(tperm));
  radar_model radar_model_i (.sys_clk_in(sys_clk_in), .request_in(req), .drop_good_in(drop),
    .range_ft_in(ft), .data_ready_out(ready), .data_good_out(good),
    .low_range_scale_out(low), .range_word_out(word), .rate_count_out(cnt));
  initial begin
    sys_clk_in = 0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  task chk(input bit ok, input string m);
    checks_done++;
    if (!ok) begin
      err_total++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  // trigger one pass and gather the pulses it produces
  task pass;
    seen = 7'h0;
    @(posedge sys_clk_in) #1 trig = 1;
    @(posedge sys_clk_in) #1 trig = 0;
    repeat (30) begin
      @(posedge sys_clk_in);
      #1 seen = seen | {pref, req, redes, fine, bk, nav, vld};
      if (vld === 1'b1) {rng, rt} = {range_out, range_rate_out};
    end
  endtask
  task t_refuse;
    grant = 0; pass(); chk(seen[5] === 1'b0, "read without grant");
    grant = 1; man = 1; pass(); chk(tperm === 1'b0 && seen[5] === 1'b0, "maneuver");
    man = 0; auto = 0; pass(); chk(seen[5] === 1'b0, "no auto mode");
    auto = 1; en = 0; pass(); chk(seen[6:4] === 3'b101, "enable lost");
    en = 1; zero = 1; rdv = 1;
    pass(); chk(seen[5] === 1'b0 && seen[3] === 1'b1, "zeroing");
    chk(frep === 2'h2, "repeat count");
    zero = 0;
    $display("test refuse done");
  endtask
  task t_read(input logic [31:0] f, input logic p, input logic n, input logic b);
    ft = f; permit = p; rng = 32'h0; pass();
    chk(seen[0] === 1'b1, "set not valid");
    chk(rng === (f < 307355 ? f / 10 * 10 : f / 100 * 100), "range");
    chk(rt === 32'd300, "range rate");
    chk(seen[1] === n, "nav update");
    chk(seen[2] === b, "backup code");
    $display("test read done");
  endtask
  // ************************************************************
  // side-lobe alarm and antenna angle
  // ************************************************************
  task t_lobe;
    line_of_sight = 16'h0004; pass(); chk(lobe === 1'b1 && seen[0] === 1'b0, "no alarm");
    proceed = 1;
    @(posedge sys_clk_in) #1 proceed = 0;
    repeat (2) @(posedge sys_clk_in);
    #1 chk(lobe === 1'b0 && vld === 1'b1, "proceed ignored");
    pass();
    redes_op = 1;
    @(posedge sys_clk_in) #1 redes_op = 0;
    chk(redes === 1'b1 && lobe === 1'b0 && vld === 1'b0, "operator redesignate");
    line_of_sight = 16'h0000; bore = 16'h001f;
    pass(); chk(seen[6] === 1'b1, "boresight beyond limit");
    bore = 16'h001e;
    pass(); chk(seen[6] === 1'b0 && seen[0] === 1'b1, "boresight at limit");
    bore = 16'h0000;
    $display("test lobe done");
  endtask
  task t_faults;
    drop = 1; pass(); chk(tfail === 1'b1 && seen[4] === 1'b1, "good lost");
    drop = 0; efail = 1; pass(); chk(seen[0] === 1'b0 && seen[4] === 1'b1, "enc fail");
    efail = 0;
    @(posedge sys_clk_in) #1 inh = 1;
    @(posedge sys_clk_in) #1 inh = 0;
    chk(inhib === 1'b1, "inhibit set");
    vsel = 1;
    @(posedge sys_clk_in) #1 vsel = 0;
    chk(inhib === 1'b0, "inhibit clear");
    $display("test faults done");
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    {trig, rdv, man, grant, zero, efail, permit, inh, vsel, drop, proceed, redes_op} = 12'h000;
    {line_of_sight, bore} = 32'h00000000;
    {en, auto, reset_in} = 3'h7;
    ft = 32'h0;
    repeat (20) @(posedge sys_clk_in);
    #1 reset_in = 0;
    t_refuse();
    rdv = 0;
    t_read(32'd12340, 1'b0, 1'b0, 1'b1);
    t_read(32'd500000, 1'b1, 1'b1, 1'b0);
    rdv = 1;
    t_read(32'd500000, 1'b1, 1'b0, 1'b0);
    t_lobe();
    t_faults();
    test_done();
  end
  // watchdog sized well past the fourteen passes of about 32 cycles each
  initial begin
    repeat (3000) @(posedge sys_clk_in);
    err_total++;
    test_done();
  end
endmodule // radar_read_sequencer_tb
